// ==== dv/bsc_bridge_model.sv ====
`timescale 1ns/100ps

module bsc_bridge_model (
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       zc_en_i,
    input  wire logic [5:0] drive_ctl_i,
    input  wire logic [2:0] edge_phase_i,
    output logic      [2:0] cmp_o
);
    // ==========================================================
    // back-emf: the watched phase crosses a fixed time after each step
    localparam int ZC_DLY = 20;
    logic [5:0] drv_q;
    int         cnt_q;
    logic [1:0] idx_w;
    logic       ok_w;
    assign idx_w = (edge_phase_i % 3 == 1) ? 2'h0 : ((edge_phase_i % 3 == 0) ? 2'h1 : 2'h2);
    assign ok_w  = (edge_phase_i != 3'h0) && (edge_phase_i != 3'h7);

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmp_o <= 3'h0;
            drv_q <= 6'h00;
            cnt_q <= 0;
        end else begin
            drv_q <= drive_ctl_i;
            if (drive_ctl_i != drv_q) begin
                cnt_q <= 0;
                // preset opposite level: only the wanted edge direction fires later
                if (ok_w) cmp_o[idx_w] <= !edge_phase_i[0];
            end else if (cnt_q < ZC_DLY) begin
                cnt_q <= cnt_q + 1;
            end else if (cnt_q == ZC_DLY && zc_en_i && ok_w) begin
                cmp_o[idx_w] <= edge_phase_i[0];
                cnt_q <= cnt_q + 1;
            end
        end
    end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps

module tb_top;
    logic        core_clk_i = 1'b0;
    logic        rst_b_i    = 1'b0;
    logic [7:0]  addr_i     = 8'h00;
    logic [15:0] wr_data_i  = 16'h0000;
    logic        wr_en_i    = 1'b0;
    logic        rd_en_i    = 1'b0;
    logic        zc_en      = 1'b0;
    logic        pwm        = 1'b0;
    logic        adc_valid  = 1'b0;
    logic [9:0]  adc_u      = 10'h000;
    logic [9:0]  adc_v      = 10'h000;
    logic [15:0] rd_data_o;
    logic [15:0] rv;
    logic [2:0]  cmp_i;
    logic [2:0]  edge_phase_o;
    logic [5:0]  drive_ctl_o;
    logic [5:0]  dv;
    logic        mon_pin;
    logic        stat_pin;
    int          err_total = 0;
    int          n_tests   = 0;

    initial forever #4 core_clk_i = ~core_clk_i;

    bsc_commutation i_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .cmp_i(cmp_i), .pwm_i(pwm), .adc_valid_i(adc_valid), .adc_u_i(adc_u),
        .adc_v_i(adc_v), .adc_w_i(10'h000), .drive_ctl_o(drive_ctl_o),
        .edge_phase_o(edge_phase_o), .comparator_monitor_pin_o(mon_pin),
        .timer_status_pin_o(stat_pin));

    bsc_bridge_model i_bridge (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .zc_en_i(zc_en),
        .drive_ctl_i(drive_ctl_o), .edge_phase_i(edge_phase_o), .cmp_o(cmp_i));

    // ==========================================================
    // shared helpers
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_en_i   <= 1'b1;
        @(posedge core_clk_i);
        wr_en_i   <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_i);
        addr_i  <= a;
        rd_en_i <= 1'b1;
        @(posedge core_clk_i);
        rd_en_i <= 1'b0;
        #1 rv = rd_data_o;
    endtask

    // a step that never comes is a hang: count it and close the run
    task automatic wait_chg(input int lim);
        dv = drive_ctl_o;
        for (int i = 0; i < lim; i++) begin
            @(posedge core_clk_i);
            #1;
            if (drive_ctl_o !== dv) return;
        end
        $display("ERROR drive step expected change seen %h", dv);
        err_total++;
        stop_test();
    endtask

    // ==========================================================
    // scenarios
    task automatic t_unforced();
        rd(8'h03);
        check("base limit", rv, 16'hFFFF);
        rd(8'h0F);
        check("unmapped", rv, 16'h0000);
        wr(8'h03, 16'h0010);
        // tick every clock: 40 clocks carry the count well past the limit
        repeat (40) @(posedge core_clk_i);
        rd(8'h05);
        check("status", rv & 16'h0007, 16'h0004);
        rd(8'h0B);
        check("count kept", {15'h0, rv > 16'h0010}, 16'h0001);
        check("drive", {10'h0, drive_ctl_o}, 16'h0000);
        $display("test unforced done");
    endtask

    task automatic t_forced();
        for (int s = 1; s < 8; s++) begin
            wr(8'h10 + 8'(s), 16'(s * 257));
        end
        wr(8'h01, 16'h0020);
        wr(8'h02, 16'h0020);
        wr(8'h03, 16'h0020);
        wr(8'h00, 16'h0001);
        wr(8'h04, 16'h0006);
        wr(8'h05, 16'h001F);
        repeat (2) @(posedge core_clk_i);
        check("drive s6", {10'h0, drive_ctl_o}, 16'h0006);
        wait_chg(100);
        check("drive s1", {10'h0, drive_ctl_o}, 16'h0001);
        rd(8'h05);
        check("status", rv & 16'h0007, 16'h0007);
        rd(8'h04);
        check("state", rv & 16'h0007, 16'h0001);
        rd(8'h0A);
        check("capture", {15'h0, rv > 16'h0020 && rv < 16'h0030}, 16'h0001);
        rd(8'h0B);
        check("restart", {15'h0, rv < 16'h0010}, 16'h0001);
        $display("test forced done");
    endtask

    task automatic t_crossing();
        zc_en <= 1'b1;
        wr(8'h03, 16'h0040);
        wait_chg(100);
        wr(8'h05, 16'h001F);
        wait_chg(100);
        rd(8'h05);
        check("status", rv & 16'h001D, 16'h0019);
        check("edge sel", {13'h0, edge_phase_o}, {13'h0, drive_ctl_o[2:0]});
        $display("test crossing done");
    endtask

    // state 0 and no forcing: the comparators stand still while the pins are checked
    task automatic t_debug();
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h0000);
        for (int s = 0; s < 3; s++) begin
            wr(8'h06, 16'(s << 4));
            repeat (12) @(posedge core_clk_i);
            #1 check("monitor pin", {15'h0, mon_pin}, {15'h0, cmp_i[s]});
        end
        wr(8'h06, 16'h000C);
        repeat (3) @(posedge core_clk_i);
        #1 check("status pin", {15'h0, stat_pin}, 16'h0001);
        wr(8'h06, 16'h100E);
        pwm <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1 check("window delay", {15'h0, stat_pin}, 16'h0000);
        repeat (20) @(posedge core_clk_i);
        #1 check("window on", {15'h0, stat_pin}, 16'h0001);
        wr(8'h06, 16'h100D);
        repeat (3) @(posedge core_clk_i);
        #1 check("window off", {15'h0, stat_pin}, 16'h0000);
        $display("test debug done");
    endtask

    // state 3: A=U, B=V, K rising; only that choice turns the sign
    task automatic t_adc();
        wr(8'h07, 16'h0040);
        wr(8'h00, 16'h0040);
        adc_u     <= 10'h100;
        adc_v     <= 10'h0A0;
        adc_valid <= 1'b1;
        wr(8'h04, 16'h0003);
        wr(8'h05, 16'h001F);
        adc_u <= 10'h200;
        wait_chg(100);
        check("adc step", {10'h0, drive_ctl_o}, 16'h0004);
        rd(8'h05);
        check("adc detect", rv & 16'h0008, 16'h0008);
        $display("test adc done");
    endtask

    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        t_unforced();
        t_forced();
        t_crossing();
        t_debug();
        t_adc();
        stop_test();
    end
endmodule

// ==== logic/bsc_commutation.sv ====
`timescale 1ns/100ps
`include "bsc_defs.svh"

module bsc_commutation (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    output logic      [15:0] rd_data_o,
    input  wire logic [2:0]  cmp_i,
    input  wire logic        pwm_i,
    input  wire logic        adc_valid_i,
    input  wire logic [9:0]  adc_u_i,
    input  wire logic [9:0]  adc_v_i,
    input  wire logic [9:0]  adc_w_i,
    output logic      [5:0]  drive_ctl_o,
    output logic      [2:0]  edge_phase_o,
    output logic             comparator_monitor_pin_o,
    output logic             timer_status_pin_o
);

    // ======================================================
    // register file
    bsc_pkg::bsc_word_t ctrl_q;
    logic [6:0]         mask_angle_select_q;
    logic [6:0]         commutation_angle_select_q;
    bsc_pkg::bsc_word_t base_limit_q;
    logic [2:0]         commutation_state_q;
    logic [2:0]         commutation_state_d;
    logic [4:0]         status_q;
    logic [4:0]         status_set;
    bsc_pkg::bsc_word_t cmp_cfg_q;
    logic [7:0]         rising_coefficient_q;
    logic [7:0]         falling_coefficient_q;
    bsc_pkg::bsc_word_t state_drive_pattern_q [1:7];

    wire forced_commutation_enable = ctrl_q[`BSC_CTRL_FORCE];
    wire [1:0] base_time_filter_select = ctrl_q[`BSC_CTRL_FLT_LO +: 2];
    wire [2:0] psc_sel = ctrl_q[`BSC_CTRL_PSC_LO +: 3];
    wire adc_mode = ctrl_q[`BSC_CTRL_ADC];
    wire [1:0] sampling_window_select = cmp_cfg_q[1:0];
    wire [1:0] debug_output_select = cmp_cfg_q[3:2];
    wire [1:0] comparator_monitor_select = cmp_cfg_q[5:4];
    wire [7:0] sampling_delay_setting = cmp_cfg_q[`BSC_CFG_DLY_LO +: 8];

    wire wr_ctrl   = wr_en_i && addr_i == `BSC_OFS_CTRL;
    wire wr_mask   = wr_en_i && addr_i == `BSC_OFS_MASK_ANG;
    wire wr_comm   = wr_en_i && addr_i == `BSC_OFS_COMM_ANG;
    wire wr_lim    = wr_en_i && addr_i == `BSC_OFS_BASE_LIM;
    wire wr_state  = wr_en_i && addr_i == `BSC_OFS_STATE;
    wire wr_status = wr_en_i && addr_i == `BSC_OFS_STATUS;
    wire wr_cfg    = wr_en_i && addr_i == `BSC_OFS_CMP_CFG;
    wire wr_kr     = wr_en_i && addr_i == `BSC_OFS_K_RISE;
    wire wr_kf     = wr_en_i && addr_i == `BSC_OFS_K_FALL;
    wire [7:0] pat_idx = addr_i - `BSC_OFS_PAT_BASE;
    wire wr_pat    = wr_en_i && addr_i > `BSC_OFS_PAT_BASE
                     && addr_i < `BSC_OFS_PAT_BASE + 8'h08;

    // ======================================================
    // timer prescaler: tick every 2^psc_sel clocks
    logic [6:0] psc_cnt_q;
    wire  [6:0] psc_mask = 7'(~(7'h7F << psc_sel));
    wire        tick = (psc_cnt_q & psc_mask) == psc_mask;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            psc_cnt_q <= 7'h00;
        end else begin
            psc_cnt_q <= psc_cnt_q + 7'h01;
        end
    end

    // ======================================================
    // comparator synchroniser and stability filter
    logic [2:0] cmp_s1_q;
    logic [2:0] cmp_s2_q;
    logic [2:0] cmp_s3_q;
    logic [2:0] cmp_filt_q;
    logic [2:0] cmp_lvl_q;
    logic [2:0] cmp_lvl_prev_q;
    wire  [2:0] cmp_agree = ~(cmp_s2_q ^ cmp_s3_q);
    wire  [2:0] cmp_filt_d = (cmp_agree & cmp_s3_q) | (~cmp_agree & cmp_filt_q);

    // pwm comes from logic on this clock, so no synchroniser
    logic       pwm_prev_q;
    logic [7:0] dly_cnt_q;
    // windows 1 to 3 stay shut in the cycle of a pwm edge, before the counter restarts; window 0 stays open
    wire        delay_ok = pwm_i == pwm_prev_q && dly_cnt_q >= sampling_delay_setting;
    wire        sample_win;

    assign sample_win =
        (sampling_window_select == 2'h0) ? 1'b1 :
        (sampling_window_select == 2'h1) ? (!pwm_i && delay_ok) :
        (sampling_window_select == 2'h2) ? (pwm_i && delay_ok) :
        delay_ok;

    bsc_pkg::bsc_phase_t phase_q;
    wire masking = phase_q == bsc_pkg::PH_MASK;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmp_s1_q       <= 3'h0;
            cmp_s2_q       <= 3'h0;
            cmp_s3_q       <= 3'h0;
            cmp_filt_q     <= 3'h0;
            cmp_lvl_q      <= 3'h0;
            cmp_lvl_prev_q <= 3'h0;
            pwm_prev_q     <= 1'b0;
            dly_cnt_q      <= 8'h00;
        end else begin
            cmp_s1_q       <= cmp_i;
            cmp_s2_q       <= cmp_s1_q;
            cmp_s3_q       <= cmp_s2_q;
            cmp_filt_q     <= cmp_filt_d;
            pwm_prev_q     <= pwm_i;
            cmp_lvl_prev_q <= cmp_lvl_q;
            if (pwm_i != pwm_prev_q) begin
                dly_cnt_q <= 8'h00;
            end else if (dly_cnt_q != 8'hFF) begin
                dly_cnt_q <= dly_cnt_q + 8'h01;
            end
            if (sample_win && !masking) begin
                cmp_lvl_q <= cmp_filt_q;
            end
        end
    end

    // ======================================================
    // crossing detection, comparator and adc paths
    logic [2:0] eps_q;
    wire  [2:0] rise = cmp_lvl_q & ~cmp_lvl_prev_q;
    wire  [2:0] fall = ~cmp_lvl_q & cmp_lvl_prev_q;
    // bit 0 = U, bit 1 = V, bit 2 = W
    wire cmp_edge =
        (eps_q == 3'h1) ? rise[0] : (eps_q == 3'h2) ? fall[2] :
        (eps_q == 3'h3) ? rise[1] : (eps_q == 3'h4) ? fall[0] :
        (eps_q == 3'h5) ? rise[2] : (eps_q == 3'h6) ? fall[1] :
        (eps_q == 3'h7) ? |(rise | fall) : 1'b0;

    wire [9:0] adc_a =
        (eps_q == 3'h2 || eps_q == 3'h3) ? adc_u_i :
        (eps_q == 3'h4 || eps_q == 3'h5) ? adc_v_i : adc_w_i;
    wire [9:0] adc_b =
        (eps_q == 3'h1 || eps_q == 3'h4) ? adc_u_i :
        (eps_q == 3'h3 || eps_q == 3'h6) ? adc_v_i : adc_w_i;
    wire [7:0] adc_k = eps_q[0] ? rising_coefficient_q : falling_coefficient_q;
    wire [17:0] ka = adc_k * adc_a;
    wire signed [18:0] adc_res =
        $signed({1'b0, 18'(ka >> `BSC_K_SHIFT)}) - $signed({9'h000, adc_b});
    logic adc_sign_q;
    logic adc_have_q;
    wire  adc_sample = adc_valid_i && eps_q != 3'h0 && eps_q != 3'h7;
    wire  adc_edge = adc_sample && adc_have_q && adc_res[18] != adc_sign_q;
    wire  zc_raw = adc_mode ? adc_edge : cmp_edge;

    // ======================================================
    // base and reload counters, commutation sequencing
    bsc_pkg::bsc_word_t base_counter_q;
    bsc_pkg::bsc_word_t reload_counter_q;
    bsc_pkg::bsc_word_t reload_limit_q;
    bsc_pkg::bsc_word_t sixty_degree_capture_q;
    bsc_pkg::bsc_word_t sixty_degree_base_time_q;
    bsc_pkg::bsc_word_t hist_q [0:`BSC_HIST_DEPTH-1];
    logic               reload_run_enable_q;
    logic               zc_seen_q;
    logic               bovf_done_q;
    logic               cap_pend_q;

    wire reload_ovf = tick && reload_run_enable_q
                      && reload_counter_q == reload_limit_q;
    wire base_over = base_counter_q > base_limit_q;
    wire zc_take = zc_raw && phase_q == bsc_pkg::PH_SEARCH;
    // an overflow already flagged while unforced must not block a later forced step
    wire force_comm = tick && base_over && forced_commutation_enable
                      && !zc_seen_q;
    wire bovf_free = base_over && !forced_commutation_enable && !bovf_done_q;
    wire comm = force_comm
                || (phase_q == bsc_pkg::PH_DELAY && reload_ovf);
    wire mask_end = masking && reload_ovf;

    wire [22:0] mask_prod = sixty_degree_base_time_q * mask_angle_select_q;
    wire [22:0] comm_prod = sixty_degree_base_time_q * commutation_angle_select_q;
    wire [15:0] mask_time = 16'(mask_prod >> `BSC_ANGLE_SHIFT);
    wire [15:0] comm_time = 16'(comm_prod >> `BSC_ANGLE_SHIFT);

    logic [18:0] flt_acc;
    always_comb begin
        flt_acc = 19'h00000;
        for (int i = 0; i < `BSC_HIST_DEPTH; i++) begin
            if (i < (1 << base_time_filter_select)) begin
                flt_acc = flt_acc + 19'(hist_q[i]);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            base_counter_q <= 16'h0000;
        end else if (comm) begin
            base_counter_q <= 16'h0000;
        end else if (tick && base_counter_q != 16'hFFFF) begin
            base_counter_q <= base_counter_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reload_counter_q    <= 16'h0000;
            reload_run_enable_q <= 1'b0;
            reload_limit_q      <= 16'h0000;
        end else if (comm) begin
            reload_counter_q    <= 16'h0000;
            reload_run_enable_q <= 1'b1;
            reload_limit_q      <= mask_time;
        end else if (zc_take) begin
            reload_counter_q    <= 16'h0000;
            reload_run_enable_q <= 1'b1;
            reload_limit_q      <= comm_time;
        end else if (reload_ovf) begin
            reload_counter_q    <= 16'h0000;
            reload_run_enable_q <= 1'b0;
        end else if (tick && reload_run_enable_q) begin
            reload_counter_q    <= reload_counter_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_q     <= bsc_pkg::PH_IDLE;
            zc_seen_q   <= 1'b0;
            bovf_done_q <= 1'b0;
            adc_sign_q  <= 1'b0;
            adc_have_q  <= 1'b0;
        end else begin
            if (adc_sample) begin
                adc_sign_q <= adc_res[18];
                adc_have_q <= 1'b1;
            end
            if (comm) begin
                phase_q     <= bsc_pkg::PH_MASK;
                zc_seen_q   <= 1'b0;
                bovf_done_q <= 1'b0;
            end else begin
                if (force_comm || bovf_free) begin
                    bovf_done_q <= 1'b1;
                end
                if (mask_end) begin
                    phase_q <= bsc_pkg::PH_SEARCH;
                end else if (zc_take) begin
                    phase_q   <= bsc_pkg::PH_DELAY;
                    zc_seen_q <= 1'b1;
                end
            end
        end
    end

    // capture now, filtered base time one cycle later
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sixty_degree_capture_q   <= 16'h0000;
            sixty_degree_base_time_q <= 16'h0000;
            cap_pend_q               <= 1'b0;
            for (int i = 0; i < `BSC_HIST_DEPTH; i++) begin
                hist_q[i] <= 16'h0000;
            end
        end else begin
            cap_pend_q <= comm;
            if (comm) begin
                sixty_degree_capture_q <= base_counter_q;
                hist_q[0]              <= base_counter_q;
                for (int i = 1; i < `BSC_HIST_DEPTH; i++) begin
                    hist_q[i] <= hist_q[i-1];
                end
            end
            if (cap_pend_q) begin
                sixty_degree_base_time_q <= 16'(flt_acc >> base_time_filter_select);
            end
        end
    end

    // ======================================================
    // state machine, drive pattern transfer, flags
    assign commutation_state_d =
        (commutation_state_q == 3'h6) ? 3'h1 :
        (commutation_state_q != 3'h0 && commutation_state_q != 3'h7)
            ? commutation_state_q + 3'h1 : commutation_state_q;

    wire [2:0] next_state = wr_state ? wr_data_i[2:0]
                          : comm ? commutation_state_d : commutation_state_q;
    wire [15:0] next_pat = (next_state == 3'h0) ? 16'h0000
                         : state_drive_pattern_q[next_state];

    assign status_set = {mask_end,
                         zc_take,
                         force_comm || bovf_free,
                         comm || reload_ovf,
                         comm};

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            commutation_state_q <= 3'h0;
            drive_ctl_o         <= 6'h00;
            eps_q               <= 3'h0;
            status_q            <= 5'h00;
        end else begin
            commutation_state_q <= next_state;
            if (comm || wr_state) begin
                drive_ctl_o <= next_pat[5:0];
                eps_q       <= next_pat[`BSC_PAT_EPS_LO +: 3];
            end
            // a new event beats a write-one-to-clear in the same cycle
            status_q <= (status_q & ~(wr_status ? wr_data_i[4:0] : 5'h00))
                        | status_set;
        end
    end
    assign edge_phase_o = eps_q;

    // ======================================================
    // software writes and read-back
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_q                     <= `BSC_RST_CTRL;
            mask_angle_select_q        <= 7'h00;
            commutation_angle_select_q <= 7'h00;
            base_limit_q               <= `BSC_RST_LIMIT;
            cmp_cfg_q                  <= 16'h0000;
            rising_coefficient_q       <= 8'h00;
            falling_coefficient_q      <= 8'h00;
            for (int i = 1; i < 8; i++) begin
                state_drive_pattern_q[i] <= 16'h0000;
            end
        end else begin
            if (wr_ctrl) ctrl_q <= wr_data_i;
            if (wr_mask) mask_angle_select_q <= wr_data_i[6:0];
            if (wr_comm) commutation_angle_select_q <= wr_data_i[6:0];
            if (wr_lim) base_limit_q <= wr_data_i;
            if (wr_cfg) cmp_cfg_q <= wr_data_i;
            if (wr_kr) rising_coefficient_q <= wr_data_i[7:0];
            if (wr_kf) falling_coefficient_q <= wr_data_i[7:0];
            if (wr_pat) state_drive_pattern_q[pat_idx[2:0]] <= wr_data_i;
        end
    end

    wire [15:0] rd_mux =
        (addr_i == `BSC_OFS_CTRL)      ? ctrl_q :
        (addr_i == `BSC_OFS_MASK_ANG)  ? {9'h000, mask_angle_select_q} :
        (addr_i == `BSC_OFS_COMM_ANG)  ? {9'h000, commutation_angle_select_q} :
        (addr_i == `BSC_OFS_BASE_LIM)  ? base_limit_q :
        (addr_i == `BSC_OFS_STATE)     ? {13'h0000, commutation_state_q} :
        (addr_i == `BSC_OFS_STATUS)    ? {11'h000, status_q} :
        (addr_i == `BSC_OFS_CMP_CFG)   ? cmp_cfg_q :
        (addr_i == `BSC_OFS_K_RISE)    ? {8'h00, rising_coefficient_q} :
        (addr_i == `BSC_OFS_K_FALL)    ? {8'h00, falling_coefficient_q} :
        (addr_i == `BSC_OFS_BASE_TIME) ? sixty_degree_base_time_q :
        (addr_i == `BSC_OFS_CAPTURE)   ? sixty_degree_capture_q :
        (addr_i == `BSC_OFS_BASE_CNT)  ? base_counter_q :
        (wr_pat || (rd_en_i && addr_i > `BSC_OFS_PAT_BASE
                    && addr_i < `BSC_OFS_PAT_BASE + 8'h08))
            ? state_drive_pattern_q[pat_idx[2:0]] : 16'h0000;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o                <= 16'h0000;
            comparator_monitor_pin_o <= 1'b0;
            timer_status_pin_o       <= 1'b0;
        end else begin
            rd_data_o <= rd_en_i ? rd_mux : 16'h0000;
            comparator_monitor_pin_o <=
                (comparator_monitor_select == 2'h1) ? cmp_filt_q[1] :
                (comparator_monitor_select == 2'h2) ? cmp_filt_q[2] : cmp_filt_q[0];
            // other debug selections show whether the reload timer runs
            timer_status_pin_o <= (debug_output_select == 2'h3)
                ? sample_win : reload_run_enable_q;
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence comm_seq;
        comm ##1 (base_counter_q == 16'h0000);
    endsequence

    base_restart_a: assert property (comm |-> comm_seq)
        else $error("base counter not restarted on commutation");
    capture_a: assert property (comm |=> sixty_degree_capture_q == $past(base_counter_q))
        else $error("capture missed");
    mask_start_a: assert property (comm |=> reload_run_enable_q && phase_q == bsc_pkg::PH_MASK
                                   && reload_limit_q == $past(mask_time))
        else $error("masking not started");
    state_step_a: assert property (comm && !wr_state && commutation_state_q == 3'h3
                                   |=> commutation_state_q == 3'h4)
        else $error("state did not advance");
    flag_raise_a: assert property (comm |=> status_q[`BSC_ST_WT] && status_q[`BSC_ST_ROVF])
        else $error("commutation flags missing");
    no_force_a: assert property (zc_seen_q |-> !force_comm)
        else $error("forced after crossing");
    free_run_a: assert property (base_over && !forced_commutation_enable
                                 |-> !comm || phase_q == bsc_pkg::PH_DELAY)
        else $error("unforced commutation");
    mask_hold_a: assert property (masking && $past(masking)
                                  |-> $stable(cmp_lvl_q))
        else $error("level changed in masking");
    reload_ovf_a: assert property (reload_ovf && !comm && !zc_take
                                   |=> !reload_run_enable_q && reload_counter_q == 16'h0000)
        else $error("reload did not stop");
    mask_flag_a: assert property (mask_end && !comm |=> status_q[`BSC_ST_MEND]
                                  && phase_q == bsc_pkg::PH_SEARCH)
        else $error("mask end not flagged");

endmodule

// ==== logic/bsc_defs.svh ====
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

// ==========================================================
// register offsets
`define BSC_OFS_CTRL      8'h00
`define BSC_OFS_MASK_ANG  8'h01
`define BSC_OFS_COMM_ANG  8'h02
`define BSC_OFS_BASE_LIM  8'h03
`define BSC_OFS_STATE     8'h04
`define BSC_OFS_STATUS    8'h05
`define BSC_OFS_CMP_CFG   8'h06
`define BSC_OFS_K_RISE    8'h07
`define BSC_OFS_K_FALL    8'h08
`define BSC_OFS_BASE_TIME 8'h09
`define BSC_OFS_CAPTURE   8'h0A
`define BSC_OFS_BASE_CNT  8'h0B
`define BSC_OFS_PAT_BASE  8'h10

// ==========================================================
// field positions
`define BSC_CTRL_FORCE    0
`define BSC_CTRL_FLT_LO   1
`define BSC_CTRL_PSC_LO   3
`define BSC_CTRL_ADC      6
`define BSC_ST_WT         0
`define BSC_ST_ROVF       1
`define BSC_ST_BOVF       2
`define BSC_ST_PD         3
`define BSC_ST_MEND       4
`define BSC_CFG_DLY_LO    8
`define BSC_PAT_EPS_LO    8

// ==========================================================
// reset values and fixed counts
`define BSC_RST_CTRL      16'h0000
`define BSC_RST_LIMIT     16'hFFFF
`define BSC_ANGLE_SHIFT   7
`define BSC_K_SHIFT       7
`define BSC_HIST_DEPTH    8

`endif

// ==== logic/bsc_pkg.sv ====
package bsc_pkg;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_MASK,
        PH_SEARCH,
        PH_DELAY
    } bsc_phase_t;

    typedef logic [15:0] bsc_word_t;

endpackage
